// file: hdl/fxos_pkg.sv
package fxos_pkg;
    // Quantization modes.
    typedef enum logic [1:0] {
        FXOS_Q_TRUNC = 2'h0,
        FXOS_Q_SYM   = 2'h1,
        FXOS_Q_CONV  = 2'h2
    } fxos_quant_e;
    // Overflow modes.
    typedef enum logic [1:0] {
        FXOS_O_WRAP = 2'h0,
        FXOS_O_SAT  = 2'h1,
        FXOS_O_FLAG = 2'h2
    } fxos_ovf_e;
    localparam int FXOS_IN_W      = 24;
    localparam int FXOS_IN_FRAC   = 12;
    localparam int FXOS_OUT_W     = 16;
    localparam int FXOS_OUT_FRAC  = 8;
    localparam int FXOS_MAX_W     = 4096;
    localparam int FXOS_LATENCY   = 1;
    localparam int FXOS_BUF_DEPTH = 2;
    localparam int FXOS_APB_W     = 32;
    localparam logic [11:0] FXOS_A_CTRL   = 12'h000;
    localparam logic [11:0] FXOS_A_STATUS = 12'h004;
    localparam int FXOS_C_QUANT  = 0;
    localparam int FXOS_C_OVF    = 2;
    localparam int FXOS_C_SIGNED = 4;
    localparam int FXOS_C_USER   = 5;
    localparam int FXOS_C_CLR    = 6;
    localparam logic [31:0] FXOS_CTRL_RST = 32'h0000_0030;
endpackage

// file: hdl/fxos_buf.sv
`timescale 1ns/10ps
// Two-entry skid buffer; a stall downstream loses no word.
module fxos_buf #(
    parameter int W     = 16,
    parameter int DEPTH = 2
) (
    input  wire logic         i_clk,
    input  wire logic         i_rst,
    input  wire logic         i_clr,
    input  wire logic         i_valid,
    output logic              o_ready,
    input  wire logic [W-1:0] i_data,
    output logic              o_valid,
    input  wire logic         i_ready,
    output logic [W-1:0]      o_data
);
    logic [W-1:0] mem_r [DEPTH];
    logic [1:0]   cnt_r;
    logic         wr_ptr_r;
    logic         rd_ptr_r;
    logic         push;
    logic         pop;

    assign o_ready = (cnt_r != 2'(DEPTH));
    assign o_valid = (cnt_r != 2'h0);
    assign o_data  = mem_r[rd_ptr_r];
    assign push    = i_valid && o_ready;
    assign pop     = o_valid && i_ready;

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            cnt_r    <= 2'h0;
            wr_ptr_r <= 1'b0;
            rd_ptr_r <= 1'b0;
        end else if (i_clr) begin
            cnt_r    <= 2'h0;
            wr_ptr_r <= 1'b0;
            rd_ptr_r <= 1'b0;
        end else begin
            cnt_r <= cnt_r + 2'(push) - 2'(pop);
            if (push) begin
                wr_ptr_r <= ~wr_ptr_r;
            end
            if (pop) begin
                rd_ptr_r <= ~rd_ptr_r;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (push) begin
            mem_r[wr_ptr_r] <= i_data;
        end
    end
endmodule

// file: hdl/fxos_top.sv
`timescale 1ns/10ps
module fxos_top #(
    parameter int IN_W     = fxos_pkg::FXOS_IN_W,
    parameter int IN_FRAC  = fxos_pkg::FXOS_IN_FRAC,
    parameter int OUT_W    = fxos_pkg::FXOS_OUT_W,
    parameter int OUT_FRAC = fxos_pkg::FXOS_OUT_FRAC,
    parameter int LATENCY  = fxos_pkg::FXOS_LATENCY
) (
    input  wire logic              I_CORE_CLK,
    input  wire logic              I_RST,
    input  wire logic              I_CLR,
    input  wire logic              I_EN,
    input  wire logic              I_VALID,
    output logic                   O_READY,
    input  wire logic [IN_W-1:0]   I_DATA,
    output logic                   O_VALID,
    input  wire logic              I_READY,
    output logic [OUT_W-1:0]       O_DATA,
    output logic [IN_W-1:0]        O_FULL_DATA,
    input  wire logic              I_PSEL,
    input  wire logic              I_PENABLE,
    input  wire logic              I_PWRITE,
    input  wire logic [11:0]       I_PADDR,
    input  wire logic [31:0]       I_PWDATA,
    output logic [31:0]            O_PRDATA,
    output logic                   O_PREADY,
    output logic                   O_PSLVERR
);
    localparam int DROP = IN_FRAC - OUT_FRAC;
    localparam int EXT  = IN_W + 2;

    initial begin
        if (OUT_W < 1 || OUT_W > fxos_pkg::FXOS_MAX_W) begin
            $error("output width out of range");
        end
        if (OUT_FRAC < 0 || OUT_FRAC > OUT_W) begin
            $error("fraction length out of range");
        end
        if (DROP < 1 || DROP >= IN_W || LATENCY < 1) begin
            $error("unsupported format");
        end
    end

    logic [31:0] ctrl_r;
    logic        sticky_r;
    logic [31:0] prdata_r;
    logic        pready_r;
    logic        pslverr_r;
    logic        apb_acc;
    logic        clr;
    logic        sgn;
    logic        user;
    logic [1:0]  qmode;
    logic [1:0]  omode;

    assign apb_acc = I_PSEL && I_PENABLE && !pready_r;
    assign sgn     = ctrl_r[fxos_pkg::FXOS_C_SIGNED];
    assign user    = ctrl_r[fxos_pkg::FXOS_C_USER];
    assign qmode   = ctrl_r[fxos_pkg::FXOS_C_QUANT +: 2];
    assign omode   = ctrl_r[fxos_pkg::FXOS_C_OVF +: 2];
    // Software clear is merged with the pin so both act synchronously.
    assign clr = I_CLR || ctrl_r[fxos_pkg::FXOS_C_CLR];

    // The slave answers one cycle into the access phase.
    always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
        if (I_RST) begin
            ctrl_r    <= fxos_pkg::FXOS_CTRL_RST;
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h0000_0000;
        end else begin
            pready_r  <= apb_acc;
            pslverr_r <= 1'b0;
            ctrl_r[fxos_pkg::FXOS_C_CLR] <= 1'b0;
            if (apb_acc) begin
                prdata_r <= 32'h0000_0000;
                case (I_PADDR)
                    fxos_pkg::FXOS_A_CTRL: begin
                        if (I_PWRITE) begin
                            ctrl_r <= I_PWDATA & 32'h0000_007F;
                        end else begin
                            prdata_r <= ctrl_r;
                        end
                    end
                    fxos_pkg::FXOS_A_STATUS: begin
                        if (!I_PWRITE) begin
                            prdata_r <= {31'h0, sticky_r};
                        end
                    end
                    default: pslverr_r <= 1'b1;
                endcase
            end
        end
    end
    assign O_PRDATA  = prdata_r;
    assign O_PREADY  = pready_r;
    assign O_PSLVERR = pslverr_r;

    // Quantization first, so a rounding carry reaches the range check.
    logic signed [EXT-1:0] x_ext;
    logic signed [EXT-1:0] q_val;
    logic [DROP-1:0]       frac;
    logic                  half;
    logic                  above;
    logic                  neg;
    logic                  inc;
    logic signed [EXT-1:0] max_v;
    logic signed [EXT-1:0] min_v;
    logic [OUT_W-1:0]      res;
    logic                  ovf;

    always_comb begin
        x_ext = sgn ? EXT'(signed'(I_DATA)) : EXT'(I_DATA);
        frac  = I_DATA[DROP-1:0];
        half  = frac[DROP-1];
        above = (frac[DROP-1] && (frac[DROP-2 < 0 ? 0 : DROP-2:0] != '0))
                && (DROP > 1);
        neg   = sgn && I_DATA[IN_W-1];
        case (qmode)
            fxos_pkg::FXOS_Q_SYM:
                inc = half && (above || !neg || DROP == 1 && !neg)
                      || (half && !neg);
            fxos_pkg::FXOS_Q_CONV:
                inc = half && (above || I_DATA[DROP]);
            default: inc = 1'b0;
        endcase
        // A signed increment keeps the shift arithmetic for negatives.
        q_val = (x_ext >>> DROP) + signed'(EXT'(inc));
        max_v = sgn ? EXT'((1 << (OUT_W - 1)) - 1) : EXT'((1 << OUT_W) - 1);
        min_v = sgn ? -EXT'(1 << (OUT_W - 1)) : EXT'(0);
        ovf   = (q_val > max_v) || (q_val < min_v);
        if (ovf && omode == fxos_pkg::FXOS_O_SAT) begin
            res = (q_val > max_v) ? max_v[OUT_W-1:0]
                                  : min_v[OUT_W-1:0];
        end else begin
            res = q_val[OUT_W-1:0];
        end
    end

    // Latency chain; the last stage is the skid buffer's source.
    logic [OUT_W-1:0] pipe_r [LATENCY];
    logic [IN_W-1:0]  full_r [LATENCY];
    logic [LATENCY-1:0] vld_r;
    logic buf_ready;
    logic advance;

    // Back-pressure stalls the chain as a low enable would.
    assign advance = I_EN && (buf_ready || !vld_r[LATENCY-1]);
    assign O_READY = advance;

    always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
        if (I_RST) begin
            vld_r    <= '0;
            sticky_r <= 1'b0;
        end else if (clr) begin
            vld_r    <= '0;
            sticky_r <= 1'b0;
        end else if (advance) begin
            vld_r <= LATENCY'({vld_r, I_VALID});
            if (I_VALID && ovf && user) begin
                sticky_r <= 1'b1;
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < LATENCY; g++) begin : g_pipe
            always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
                if (I_RST) begin
                    pipe_r[g] <= '0;
                    full_r[g] <= '0;
                end else if (clr) begin
                    pipe_r[g] <= '0;
                    full_r[g] <= '0;
                end else if (advance) begin
                    pipe_r[g] <= (g == 0) ? (user ? res
                                 : I_DATA[IN_W-1 -: OUT_W])
                                 : pipe_r[(g == 0) ? 0 : g - 1];
                    full_r[g] <= (g == 0) ? I_DATA
                                 : full_r[(g == 0) ? 0 : g - 1];
                end
            end
        end
    endgenerate

    logic             b_valid;
    logic [OUT_W-1:0] b_data;
    logic             b_ready_dn;
    fxos_buf #(
        .W     (OUT_W),
        .DEPTH (fxos_pkg::FXOS_BUF_DEPTH)
    ) u_buf (
        .i_clk   (I_CORE_CLK),
        .i_rst   (I_RST),
        .i_clr   (clr),
        .i_valid (vld_r[LATENCY-1] && advance),
        .o_ready (buf_ready),
        .i_data  (pipe_r[LATENCY-1]),
        .o_valid (b_valid),
        .i_ready (b_ready_dn),
        .o_data  (b_data)
    );
    assign b_ready_dn = I_READY;
    assign O_VALID    = b_valid;
    assign O_DATA     = b_data;
    assign O_FULL_DATA = full_r[LATENCY-1];

    chk_clr_empties: assert property (@(posedge I_CORE_CLK)
        disable iff (I_RST)
        clr |=> (vld_r == '0) && !sticky_r)
        else $error("clear left state");
    chk_hold_state: assert property (@(posedge I_CORE_CLK)
        disable iff (I_RST)
        (!I_EN && !clr) |=> $stable(vld_r) && $stable(pipe_r[0]))
        else $error("state moved while disabled");
    chk_trunc_mode: assert property (@(posedge I_CORE_CLK)
        disable iff (I_RST)
        (qmode == fxos_pkg::FXOS_Q_TRUNC) |-> !inc)
        else $error("truncate rounded");
    chk_sat_range: assert property (@(posedge I_CORE_CLK)
        disable iff (I_RST)
        (omode == fxos_pkg::FXOS_O_SAT && ovf && q_val > max_v)
        |-> res == max_v[OUT_W-1:0])
        else $error("saturation wrong");
    chk_wrap_bits: assert property (@(posedge I_CORE_CLK)
        disable iff (I_RST)
        (omode != fxos_pkg::FXOS_O_SAT) |-> res == q_val[OUT_W-1:0])
        else $error("wrap wrong");
    chk_conv_tie: assert property (@(posedge I_CORE_CLK)
        disable iff (I_RST)
        (qmode == fxos_pkg::FXOS_Q_CONV && half && !above)
        |-> inc == I_DATA[DROP])
        else $error("convergent tie wrong");
endmodule

// file: dv/fxos_sink.sv
`timescale 1ns/10ps
// Downstream consumer; slow mode stalls about half the cycles.
module fxos_sink (
    input  wire logic i_clk,
    input  wire logic i_slow,
    input  wire logic i_hold,
    output logic      o_ready
);
    logic [15:0] lfsr_r = 16'hACE1;
    initial o_ready = 1'h1;
    always @(posedge i_clk) begin
        lfsr_r  <= {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[10]};
        o_ready <= !i_hold && (!i_slow || lfsr_r[0]);
    end
endmodule

// file: dv/fxos_top_tb.sv
`timescale 1ns/10ps
module fxos_top_tb;
    logic        clk = 1'h0, rst = 1'h1, clr = 1'h0, en = 1'h1;
    logic        iv = 1'h0, slow = 1'h0, hold = 1'h0, er, ir, ov, ordy;
    logic        psel = 1'h0, pen = 1'h0, pwr = 1'h0, prdy, perr;
    logic [11:0] pa = 12'h0;
    logic [31:0] pwd = 32'h0, rd, prd, seed = 32'h37;
    logic [23:0] id = 24'h0, fd, sid;
    logic [15:0] od, keep;
    logic [6:0]  ctl = 7'h30;
    logic [15:0] exq[$];
    logic [23:0] corner[8] = '{24'h000008, 24'h000018, 24'hFFFFF8,
        24'hFFFFE8, 24'h7FFFF8, 24'h800000, 24'h0FFFF8, 24'h7FFFFF};
    int          err_total = 0, check_count = 0, cyc = 0;

    fxos_top dut_u (.I_CORE_CLK(clk), .I_RST(rst), .I_CLR(clr),
        .I_EN(en), .I_VALID(iv), .O_READY(ordy), .I_DATA(id),
        .O_VALID(ov), .I_READY(ir), .O_DATA(od), .O_FULL_DATA(fd),
        .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(pa),
        .I_PWDATA(pwd), .O_PRDATA(prd), .O_PREADY(prdy),
        .O_PSLVERR(perr));
    fxos_sink sink_u (.i_clk(clk), .i_slow(slow), .i_hold(hold),
        .o_ready(ir));

    initial forever #10 clk = ~clk;

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // Ties are offset by one less for negatives so the floor shift rounds
    // away from zero.
    function automatic logic [15:0] exp_word(logic [23:0] x, logic [6:0] c);
        longint v, q, lo, hi;
        v = c[4] ? longint'($signed(x)) : longint'(x);
        if (!c[5]) return x[23:8];
        case (c[1:0])
            2'h1: q = v + (v < 0 ? 7 : 8);
            2'h2: q = v + 7 + longint'(x[4]);
            default: q = v;
        endcase
        q = q >>> 4;
        lo = c[4] ? -32768 : 0;
        hi = c[4] ? 32767 : 65535;
        if (c[3:2] == 2'h1) q = q > hi ? hi : (q < lo ? lo : q);
        return q[15:0];
    endfunction

    task automatic check(input string w, input logic [31:0] e, g);
        check_count++;
        if (g !== e) begin
            err_total++;
            $display("wrong value %s exp %h got %h", w, e, g);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc > 20000) begin
            err_total++;
            report_and_stop();
        end
        if (!rst && iv && ordy) exq.push_back(exp_word(id, ctl));
        if (!rst && ov && ir) begin
            if (exq.size() == 0) check("spare word", 32'h0, 32'h1);
            else check("O_DATA", 32'(exq.pop_front()), 32'(od));
        end
    end

    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        psel <= 1'h1;
        pwr  <= w;
        pa   <= a;
        pwd  <= d;
        @(posedge clk);
        pen <= 1'h1;
        do @(posedge clk); while (prdy !== 1'h1);
        rd = prd;
        er = perr;
        psel <= 1'h0;
        pen  <= 1'h0;
    endtask

    task automatic set_ctl(input logic [6:0] c);
        apb(1'h1, fxos_pkg::FXOS_A_CTRL, 32'(c));
        ctl = c;
    endtask

    task automatic send(input logic [23:0] d);
        iv <= 1'h1;
        id <= d;
        repeat (200) begin
            @(posedge clk);
            if (ordy === 1'h1) break;
        end
    endtask

    task automatic drain();
        repeat (300) begin
            @(posedge clk);
            if (exq.size() == 0 && ov === 1'h0) break;
        end
        check("left over", 32'h0, 32'(exq.size()));
    endtask

    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'h0;
        apb(1'h0, fxos_pkg::FXOS_A_CTRL, 32'h0);
        check("CTRL", fxos_pkg::FXOS_CTRL_RST, rd);
        apb(1'h0, fxos_pkg::FXOS_A_STATUS, 32'h0);
        check("STATUS", 32'h0, rd);
        apb(1'h1, 12'h008, 32'hFFFF_FFFF);
        check("unmapped", 32'h1, 32'(er));
        for (int m = 0; m < 19; m++) begin
            set_ctl(m == 18 ? 7'h10 :
                    {2'h1, m >= 9, 2'(m / 3 % 3), 2'(m % 3)});
            slow <= m[0];
            for (int k = 0; k < 16; k++) send(k < 8 ? corner[k] : 24'(xs()));
            iv <= 1'h0;
            drain();
        end
        apb(1'h0, fxos_pkg::FXOS_A_STATUS, 32'h0);
        check("STATUS", 32'h1, rd);
        set_ctl(7'h70);
        apb(1'h0, fxos_pkg::FXOS_A_CTRL, 32'h0);
        check("CTRL", 32'h30, rd);
        apb(1'h0, fxos_pkg::FXOS_A_STATUS, 32'h0);
        check("STATUS", 32'h0, rd);
        // Stall downstream so the buffer fills and must refuse.
        hold <= 1'h1;
        iv   <= 1'h1;
        sid = 24'(xs());
        id   <= sid;
        repeat (10) @(posedge clk);
        check("O_READY", 32'h0, 32'(ordy));
        iv <= 1'h0;
        en <= 1'h0;
        repeat (2) @(posedge clk);
        @(negedge clk);
        keep = od;
        repeat (4) @(negedge clk);
        check("O_READY", 32'h0, 32'(ordy));
        check("O_DATA", 32'(keep), 32'(od));
        check("O_VALID", 32'h1, 32'(ov));
        check("O_FULL_DATA", 32'(sid), 32'(fd));
        @(posedge clk);
        clr <= 1'h1;
        @(posedge clk);
        clr <= 1'h0;
        exq.delete();
        @(negedge clk);
        check("O_VALID", 32'h0, 32'(ov));
        @(posedge clk);
        en   <= 1'h1;
        hold <= 1'h0;
        drain();
        report_and_stop();
    end
endmodule
